// file: design/hw_pin_trigger_playback_ctrl.sv
`timescale 1ns/1ns
`include "trig_defs.svh"

// Operation
// RL1: rising edge plays only when enabled
// RL2: enabled rising edge plays its sequence number
// RL3: falling edge plays only when enabled
// RL4: enabled falling edge plays its sequence number
// RL5: software sets polarity for active-low pins
// RL6: mode bit selects edge or level
// RL7: auto-brake runs after pin playback ends
// RL8: boost on during pin playback if enabled
// RL9: single-line mode bit enables one-wire mode
// RL10: instant-stop lets playback end at once
// RL11: third pin options in bits seven to four
// RL12: higher priority preempts, equal uses default order
// RL13: global state reads trigger code while playing
// RL14: synchronise, apply polarity, one request per edge
// RL15: level mode plays while pin stays active
module hw_pin_trigger_playback_ctrl (
  input  wire logic          core_clk,
  input  wire logic          resetn,
  input  wire logic          hw_pin_a,
  input  wire logic          hw_pin_b,
  input  wire logic          hw_pin_c,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [7:0]         reg_rdata,
  input  wire logic          play_done,
  input  wire logic          brake_done,
  output logic               play_req,
  output trig_pkg::seq_t     play_seq,
  output trig_pkg::src_t     play_src,
  output logic               play_active,
  output logic               boost_on,
  output logic               brake_req,
  output logic               stop_now,
  output logic               single_line_mode_en,
  output logic [3:0]         glb_state
);
  import trig_pkg::*;

  function automatic prio_t pin_prio(input logic [7:0] r,
                                     input int unsigned i);
    pin_prio = r[2*i +: 2];
  endfunction

  logic [7:0]  rise_cfg [3];
  logic [7:0]  fall_cfg [3];
  logic [7:0]  mode_ab;
  logic [7:0]  mode_c;
  logic [7:0]  prio_reg;
  logic [2:0]  pin_s1;
  logic [2:0]  pin_s2;
  logic [2:0]  act_prev;
  logic [2:0]  act;
  logic [2:0]  pol;
  logic [2:0]  lvl;
  logic [2:0]  brk;
  logic [2:0]  bst;
  logic [2:0]  stp;
  logic [2:0]  rise_hit;
  logic [2:0]  fall_hit;
  logic        win_valid;
  src_t        win_idx;
  seq_t        win_seq;
  prio_t       win_prio;
  prio_t       cur_prio;
  logic        accept;
  logic        release_now;
  logic        end_now;
  logic        replay;
  trig_state_e state;
  trig_state_e next_state;

  // per-pin option bits
  // RL11: third pin nibble
  always_comb begin
    pol = {mode_c[4+`BIT_POLARITY], mode_ab[`BIT_POLARITY],
           mode_ab[4+`BIT_POLARITY]};
    lvl = {mode_c[4+`BIT_LEVEL_MODE], mode_ab[`BIT_LEVEL_MODE],
           mode_ab[4+`BIT_LEVEL_MODE]};
    brk = {mode_c[4+`BIT_AUTOBRAKE], mode_ab[`BIT_AUTOBRAKE],
           mode_ab[4+`BIT_AUTOBRAKE]};
    bst = {mode_c[4+`BIT_BOOST_EN], mode_ab[`BIT_BOOST_EN],
           mode_ab[4+`BIT_BOOST_EN]};
    stp = {mode_c[`BIT_STOP_C], mode_c[`BIT_STOP_B],
           mode_c[`BIT_STOP_A]};
  end

  // register writes
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 3; i++) begin
        rise_cfg[i] <= `RST_EDGE_CFG;
        fall_cfg[i] <= `RST_EDGE_CFG;
      end
      mode_ab  <= `RST_AB_MODE;
      mode_c   <= `RST_C_MODE_STOP;
      prio_reg <= `RST_TRIG_PRIO;
    end else if (reg_wr) begin
      case (reg_addr)
        `OFS_PIN_A_RISE:      rise_cfg[0] <= reg_wdata;
        `OFS_PIN_B_RISE:      rise_cfg[1] <= reg_wdata;
        `OFS_PIN_C_RISE:      rise_cfg[2] <= reg_wdata;
        `OFS_PIN_A_FALL:      fall_cfg[0] <= reg_wdata;
        `OFS_PIN_B_FALL:      fall_cfg[1] <= reg_wdata;
        `OFS_PIN_C_FALL:      fall_cfg[2] <= reg_wdata;
        `OFS_PIN_AB_MODE:     mode_ab     <= reg_wdata;
        `OFS_PIN_C_MODE_STOP: mode_c      <= reg_wdata;
        `OFS_TRIG_PRIO:       prio_reg    <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data lands one cycle after reg_rd
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_PIN_A_RISE:      reg_rdata <= rise_cfg[0];
        `OFS_PIN_B_RISE:      reg_rdata <= rise_cfg[1];
        `OFS_PIN_C_RISE:      reg_rdata <= rise_cfg[2];
        `OFS_PIN_A_FALL:      reg_rdata <= fall_cfg[0];
        `OFS_PIN_B_FALL:      reg_rdata <= fall_cfg[1];
        `OFS_PIN_C_FALL:      reg_rdata <= fall_cfg[2];
        `OFS_PIN_AB_MODE:     reg_rdata <= mode_ab;
        `OFS_PIN_C_MODE_STOP: reg_rdata <= mode_c;
        `OFS_TRIG_PRIO:       reg_rdata <= prio_reg;
        `OFS_GLB_STATE:       reg_rdata <= {4'h0, glb_state};
        default:              reg_rdata <= 8'h00;
      endcase
    end
  end

  // RL14: two-stage sync
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end else begin
      pin_s1 <= {hw_pin_c, hw_pin_b, hw_pin_a};
      pin_s2 <= pin_s1;
    end
  end

  // RL5: polarity folds active-low pins
  assign act = pin_s2 ^ pol;

  // a polarity change can itself look like an edge
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      act_prev <= 3'h0;
    end else begin
      act_prev <= act;
    end
  end

  // RL1: rise gated by enable
  // RL3: fall gated by enable
  // RL6: level mode starts on activation only
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      rise_hit[i] = act[i] & ~act_prev[i] & rise_cfg[i][`BIT_EDGE_EN];
      fall_hit[i] = ~act[i] & act_prev[i] & ~lvl[i]
                    & fall_cfg[i][`BIT_EDGE_EN];
    end
  end

  // RL12: strict compare keeps pin a first on ties
  // RL2: rising sequence field
  // RL4: falling sequence field
  always_comb begin
    win_valid = 1'b0;
    win_idx   = 2'd0;
    win_seq   = 7'h00;
    win_prio  = 2'd0;
    for (int i = 0; i < 3; i++) begin
      if ((rise_hit[i] | fall_hit[i]) &&
          (!win_valid || pin_prio(prio_reg, i) > win_prio)) begin
        win_valid = 1'b1;
        win_idx   = 2'(i);
        win_prio  = pin_prio(prio_reg, i);
        win_seq   = rise_hit[i] ? rise_cfg[i][`SEQ_MSB:0]
                                : fall_cfg[i][`SEQ_MSB:0];
      end
    end
  end

  // RL12: lower or equal never preempts
  assign accept = win_valid && (state != ST_PLAY || win_prio > cur_prio);
  // RL15: release of a level-mode pin
  assign release_now = (state == ST_PLAY) && lvl[play_src]
                       && !act[play_src];
  // RL10: instant stop cuts the sequence short
  assign end_now = !accept && (state == ST_PLAY) &&
                   ((release_now && stp[play_src]) ||
                    (play_done && !(lvl[play_src] && act[play_src])));
  // RL15: replay while level pin held
  assign replay = !accept && (state == ST_PLAY) && play_done
                  && lvl[play_src] && act[play_src];

  // RL7: brake follows if enabled
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  if (accept) next_state = ST_PLAY;
      ST_PLAY: begin
        if (end_now) next_state = brk[play_src] ? ST_BRAKE : ST_IDLE;
      end
      ST_BRAKE: begin
        if (accept) next_state = ST_PLAY;
        else if (brake_done) next_state = ST_IDLE;
      end
      default:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // playback request and source tracking
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      play_req <= 1'b0;
      play_seq <= 7'h00;
      play_src <= 2'd0;
      cur_prio <= 2'd0;
    end else begin
      play_req <= accept | replay;
      if (accept) begin
        play_seq <= win_seq;
        play_src <= win_idx;
        cur_prio <= win_prio;
      end
    end
  end

  // end pulses and status
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      brake_req <= 1'b0;
      stop_now  <= 1'b0;
    end else begin
      brake_req <= end_now && brk[play_src];
      stop_now  <= end_now && release_now;
    end
  end

  // RL13: trigger code while playing
  // RL8: boost per source
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      glb_state   <= `GS_STANDBY;
      play_active <= 1'b0;
      boost_on    <= 1'b0;
    end else begin
      play_active <= next_state == ST_PLAY;
      boost_on    <= next_state == ST_PLAY &&
                     bst[accept ? win_idx : play_src];
      case (next_state)
        ST_PLAY:  glb_state <= `GS_TRIG;
        ST_BRAKE: glb_state <= `GS_BRAKE;
        default:  glb_state <= `GS_STANDBY;
      endcase
    end
  end

  // RL9: one-wire mode out
  assign single_line_mode_en = mode_c[`BIT_SINGLE_LINE];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_end_brake;
    end_now && brk[play_src];
  endsequence
  sequence s_brake_shown;
    brake_req && glb_state == `GS_BRAKE;
  endsequence

  property p_rise_gate;
    rise_hit[0] |-> rise_cfg[0][`BIT_EDGE_EN] && !act_prev[0];
  endproperty
  a_rise_gate: assert property (p_rise_gate) // RL1
    else $error("rise request without enable");

  property p_rise_seq;
    accept && win_idx == 2'd0 && rise_hit[0] |=>
      play_req && play_seq == $past(rise_cfg[0][6:0]);
  endproperty
  a_rise_seq: assert property (p_rise_seq) // RL2
    else $error("rising sequence not played");

  property p_fall_gate;
    fall_hit[1] |-> fall_cfg[1][`BIT_EDGE_EN] && act_prev[1];
  endproperty
  a_fall_gate: assert property (p_fall_gate) // RL3
    else $error("fall request without enable");

  property p_fall_seq;
    accept && win_idx == 2'd1 && fall_hit[1] |=>
      play_seq == $past(fall_cfg[1][6:0]) && play_src == 2'd1;
  endproperty
  a_fall_seq: assert property (p_fall_seq) // RL4
    else $error("falling sequence not played");

  property p_level_nofall;
    lvl[2] |-> !fall_hit[2];
  endproperty
  a_level_nofall: assert property (p_level_nofall) // RL6
    else $error("fall request in level mode");

  property p_brake;
    s_end_brake |=> s_brake_shown;
  endproperty
  a_brake: assert property (p_brake) // RL7
    else $error("auto brake missing");

  property p_boost;
    boost_on |-> play_active && bst[play_src];
  endproperty
  a_boost: assert property (p_boost) // RL8
    else $error("boost outside enabled playback");

  property p_stop;
    release_now && stp[play_src] && !accept |=> stop_now ##1 !play_active;
  endproperty
  a_stop: assert property (p_stop) // RL10
    else $error("instant stop not taken");

  property p_no_preempt;
    state == ST_PLAY && win_prio <= cur_prio |=>
      play_src == $past(play_src);
  endproperty
  a_no_preempt: assert property (p_no_preempt) // RL12
    else $error("lower priority preempted");

  property p_glb;
    play_active |-> glb_state == `GS_TRIG;
  endproperty
  a_glb: assert property (p_glb) // RL13
    else $error("state code not trigger");

  property p_one_req;
    rise_hit[0] |=> !rise_hit[0];
  endproperty
  a_one_req: assert property (p_one_req) // RL14
    else $error("double request per edge");

  property p_level_hold;
    replay |=> play_req && play_active ##1 play_active;
  endproperty
  a_level_hold: assert property (p_level_hold) // RL15
    else $error("level hold not replayed");

endmodule // hw_pin_trigger_playback_ctrl

// file: design/trig_defs.svh
`ifndef TRIG_DEFS_SVH
`define TRIG_DEFS_SVH

// register offsets
`define OFS_PIN_A_RISE      8'h33
`define OFS_PIN_B_RISE      8'h34
`define OFS_PIN_C_RISE      8'h35
`define OFS_PIN_A_FALL      8'h36
`define OFS_PIN_B_FALL      8'h37
`define OFS_PIN_C_FALL      8'h38
`define OFS_PIN_AB_MODE     8'h39
`define OFS_PIN_C_MODE_STOP 8'h3A
`define OFS_TRIG_PRIO       8'h3E
`define OFS_GLB_STATE       8'h3F

// reset values
`define RST_EDGE_CFG        8'h01
`define RST_AB_MODE         8'h33
`define RST_C_MODE_STOP     8'h30
`define RST_TRIG_PRIO       8'h1B

// field positions in the edge config registers
`define BIT_EDGE_EN         7
`define SEQ_MSB             6

// per-pin option bits, counted within a 4-bit nibble
`define BIT_POLARITY        3
`define BIT_LEVEL_MODE      2
`define BIT_AUTOBRAKE       1
`define BIT_BOOST_EN        0

// shared mode register fields
`define BIT_SINGLE_LINE     3
`define BIT_STOP_A          2
`define BIT_STOP_B          1
`define BIT_STOP_C          0

// global state codes
`define GS_STANDBY          4'h0
`define GS_TRIG             4'h9
`define GS_BRAKE            4'hB

`endif

// file: design/trig_pkg.sv
package trig_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PLAY,
    ST_BRAKE
  } trig_state_e;
  typedef logic [1:0] src_t;
  typedef logic [6:0] seq_t;
  typedef logic [1:0] prio_t;
endpackage

// file: verification/hw_pin_trigger_playback_ctrl_bench.sv
`timescale 1ns/1ns
module hw_pin_trigger_playback_ctrl_bench;
  import trig_pkg::*;
  logic       core_clk, resetn, reg_wr, reg_rd, play_done, brake_done;
  logic [2:0] want, inv, pins;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       play_req, play_active, boost_on, brake_req, stop_now, one_w;
  seq_t       play_seq;
  src_t       play_src;
  logic [3:0] glb_state;
  int         fails, tests_run;

  trig_host u_trig_host (.want(want), .inv(inv), .pins(pins));
  hw_pin_trigger_playback_ctrl u_hw_pin_trigger_playback_ctrl (
    .core_clk(core_clk), .resetn(resetn), .hw_pin_a(pins[0]),
    .hw_pin_b(pins[1]), .hw_pin_c(pins[2]), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .play_done(play_done),
    .brake_done(brake_done), .play_req(play_req), .play_seq(play_seq),
    .play_src(play_src), .play_active(play_active), .boost_on(boost_on),
    .brake_req(brake_req), .stop_now(stop_now),
    .single_line_mode_en(one_w), .glb_state(glb_state));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    // idle cycle so a following strobe is not reassigned at once
    @(negedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    chk(reg_rdata, e);
    @(negedge core_clk);
  endtask

  task automatic no_req(input int n);
    repeat (n) begin
      @(negedge core_clk);
      chk(play_req, 8'h00);
    end
  endtask

  // bounded wait for a start, then judge what it carries
  task automatic wait_req(input logic [7:0] sq, input logic [7:0] src);
    int n;
    n = 0;
    // an older pulse may still stand at the call's own edge
    @(negedge core_clk);
    while (play_req !== 1'b1 && n < 12) begin
      @(negedge core_clk);
      n++;
    end
    if (play_req !== 1'b1) begin
      fails++;
      $display("BAD %0t: no play request", $time);
      stop_test();
    end else begin
      chk(play_seq, sq);
      chk(play_src, src);
      chk(glb_state, 8'h09);
      chk(play_active, 8'h01);
    end
  endtask

  task automatic done(input bit brake);
    if (brake) begin
      brake_done = 1'b1;
    end else begin
      play_done = 1'b1;
    end
    @(negedge core_clk);
    if (brake) begin
      brake_done = 1'b0;
    end else begin
      play_done = 1'b0;
    end
  endtask

  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      rd(8'h33 + i[7:0], 8'h01);
    end
    rd(8'h39, 8'h33);
    rd(8'h3A, 8'h30);
    rd(8'h3E, 8'h1B);
    rd(8'h00, 8'h00);
    chk(glb_state, 8'h00);
    chk(one_w, 8'h00);
  endtask

  task automatic t_mid_reset();
    wr(8'h36, 8'h80);
    resetn = 1'b0;
    inv = 3'b000;
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    @(negedge core_clk);
    rd(8'h36, 8'h01);
    rd(8'h3A, 8'h30);
    chk(one_w, 8'h00);
    chk(glb_state, 8'h00);
    chk(play_active, 8'h00);
  endtask

  task automatic t_rise_a();
    want[0] = 1'b1;
    no_req(8);
    want[0] = 1'b0;
    no_req(8);
    wr(8'h33, 8'h85);
    want[0] = 1'b1;
    wait_req(8'h05, 8'h00);
    chk(boost_on, 8'h01);
    rd(8'h3F, 8'h09);
    no_req(3);
    done(1'b0);
    chk(brake_req, 8'h01);
    chk(glb_state, 8'h0B);
    chk(play_active, 8'h00);
    done(1'b1);
    chk(glb_state, 8'h00);
    want[0] = 1'b0;
    no_req(6);
  endtask

  task automatic t_prio();
    wr(8'h37, 8'hAA);
    want[1] = 1'b1;
    no_req(6);
    want[1] = 1'b0;
    wait_req(8'h2A, 8'h01);
    want[0] = 1'b1;
    wait_req(8'h05, 8'h00);
    wr(8'h35, 8'h83);
    want[2] = 1'b1;
    no_req(6);
    done(1'b0);
    chk(brake_req, 8'h01);
    done(1'b1);
    want = 3'b000;
    no_req(6);
  endtask

  task automatic t_level_c();
    int n;
    // disable first: a polarity flip looks like an edge
    wr(8'h35, 8'h11);
    wr(8'h3A, 8'hC9);
    chk(one_w, 8'h01);
    rd(8'h3A, 8'hC9);
    inv[2] = 1'b1;
    no_req(4);
    wr(8'h35, 8'h91);
    want[2] = 1'b1;
    wait_req(8'h11, 8'h02);
    chk(boost_on, 8'h00);
    done(1'b0);
    chk(play_req, 8'h01);
    want[2] = 1'b0;
    n = 0;
    while (stop_now !== 1'b1 && n < 8) begin
      @(negedge core_clk);
      n++;
    end
    chk(stop_now, 8'h01);
    repeat (2) @(negedge core_clk);
    chk(glb_state, 8'h00);
    chk(play_active, 8'h00);
  endtask

  initial begin
    fails = 0;
    tests_run = 0;
    resetn = 1'b0;
    want = 3'b000;
    inv = 3'b000;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    play_done = 1'b0;
    brake_done = 1'b0;
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
    @(negedge core_clk);
    t_reset();
    t_rise_a();
    t_prio();
    t_level_c();
    t_mid_reset();
    stop_test();
  end
endmodule // hw_pin_trigger_playback_ctrl_bench

// file: verification/trig_host.sv
`timescale 1ns/1ns
// host side of the three trigger pins
module trig_host (
  input  wire logic [2:0] want,
  input  wire logic [2:0] inv,
  output logic [2:0]      pins
);
  assign pins = want ^ inv;
endmodule // trig_host
